// *** core/io_matrix_regs.vh ***
/*
 * Register map, field positions and timing counts for the
 * input conditioning and output matrix block.
 * Assumes a 10 MHz APB clock and byte addresses on a 12-bit paddr.
 */
`ifndef IO_MATRIX_REGS_VH
`define IO_MATRIX_REGS_VH

// Clock and delay step
`define CLK_MHZ 10
`define DLY_STEP_US 10000
`define DLY_STEP_CYCLES (`DLY_STEP_US * `CLK_MHZ)
// Delay limit: 60.00 s in 10 ms steps
`define DLY_MAX 13'h1770
`define DLY_W 13

// Single registers (byte addresses)
`define ADDR_STATUS 12'h000
`define ADDR_SOFT_IN 12'h004
`define ADDR_CTRL 12'h008
`define ADDR_RELEASE 12'h00c
`define ADDR_DEST 12'h010
`define ADDR_LATCH 12'h014
// Arrays: config and counter per field input, mask pair per destination
`define BASE_CFG 5'h02
`define BASE_CNT 5'h04
`define BASE_MASK 4'h4

// Control register fields
`define CTRL_SOFT_EV 0
`define CTRL_REL_SEL_LO 8
`define CTRL_REL_EN 16

// Input config register fields
`define CFG_INVERT 16
`define CFG_INDICATE 17
`define CFG_ON_EV 18
`define CFG_OFF_EV 19

`define CNT_W 16
`endif

// *** core/io_matrix.v ***
/*
 * Field input conditioning, soft inputs and outputs, and output matrix
 * with latching, behind an APB slave.
 * Assumes field inputs and matrix sources synchronous to pclk, and
 * N_IN + 10 + N_EXT no larger than 64.
 */
// Operation
// - Status bit per input, 1 means active
// - Per-input 16-bit active edge counter, writable
// - Same 0-60 s delay for on and off
// - Inversion selects rising or falling active edge
// - Indication enable raises pop-up on active edge
// - On-event enable gates active edge events
// - Off-event enable gates inactive edge events
// - Four soft inputs act as matrix sources
// - Soft input state written and held
// - Six soft outputs are destinations and sources
// - Any source routes to any destination
// - Alarm, trip and three general indicators
// - Recorder trigger is a matrix destination
// - Non-latched destination follows its drive
// - Latched destination holds until release
// - One release clears all latched destinations
// - Release from keypad, command or chosen input
// - Writing release register issues release
`include "io_matrix_regs.vh"
`default_nettype none

module io_matrix #(
	parameter N_IN = 32,
	parameter N_EXT = 16,
	parameter N_RELAY = 8,
	parameter TICK_CYCLES = `DLY_STEP_CYCLES
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg pslverr,
	input wire [N_IN-1:0] field_input,
	input wire [N_EXT-1:0] ext_source,
	input wire release_key,
	input wire release_comm,
	output reg [N_IN-1:0] on_event,
	output reg [N_IN-1:0] off_event,
	output reg [N_IN-1:0] popup_req,
	output reg [3:0] soft_event,
	output reg [3:0] soft_input,
	output wire [N_RELAY-1:0] relay_out,
	output wire alarm_led,
	output wire trip_led,
	output wire [2:0] gp_led,
	output wire waveform_recorder_trigger,
	output wire [5:0] soft_out
);
	localparam ND = N_RELAY + 12;
	localparam NL = N_RELAY + 5;

	integer i;
	integer d;

	// Configuration
	reg [N_IN-1:0] invert;
	reg [N_IN-1:0] indicate;
	reg [N_IN-1:0] on_en;
	reg [N_IN-1:0] off_en;
	reg [`DLY_W-1:0] delay [0:N_IN-1];
	reg [`CNT_W-1:0] count [0:N_IN-1];
	reg [31:0] mask_lo [0:ND-1];
	reg [31:0] mask_hi [0:ND-1];
	reg soft_ev_en;
	reg [4:0] rel_sel;
	reg rel_en;
	reg [NL-1:0] latch_cfg;
	reg rel_wr;

	// Conditioning state
	reg [`DLY_W-1:0] timer [0:N_IN-1];
	reg [N_IN-1:0] status;
	reg [N_IN-1:0] status_d;
	reg [3:0] soft_input_d;
	reg [31:0] presc;
	reg tick;
	reg [ND-1:0] dq;

	wire [N_IN-1:0] corrected;
	wire [N_IN-1:0] act_edge;
	wire [N_IN-1:0] inact_edge;
	wire access;
	wire wr;
	wire setup;
	wire release_all;

	reg [63:0] src;
	reg [31:0] status32;
	reg [ND-1:0] drive;
	reg [31:0] rdata;
	reg rvalid;
	reg [4:0] idx;
	reg [4:0] didx;

	// Single-cycle access phase; read data is captured during setup
	assign access = psel & penable;
	assign setup = psel & ~penable;
	assign wr = access & pwrite;
	assign pready = access;

	// Polarity correction ahead of the delay, so the delay acts on active level
	assign corrected = field_input ^ invert;
	assign act_edge = status & ~status_d;
	assign inact_edge = ~status & status_d;

	// Delay step prescaler, 10 ms per tick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc <= 32'h00000000;
			tick <= 1'b0;
		end else if (presc >= TICK_CYCLES - 1) begin
			presc <= 32'h00000000;
			tick <= 1'b1;
		end else begin
			presc <= presc + 32'h00000001;
			tick <= 1'b0;
		end
	end

	// Definite delay per input; mismatch must persist for the whole delay
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 0; i < N_IN; i = i + 1)
				timer[i] <= {`DLY_W{1'b0}};
			status <= {N_IN{1'b0}};
			status_d <= {N_IN{1'b0}};
		end else begin
			status_d <= status;
			for (i = 0; i < N_IN; i = i + 1) begin
				if (corrected[i] == status[i]) begin
					timer[i] <= {`DLY_W{1'b0}};
				end else if (timer[i] >= delay[i]) begin
					status[i] <= corrected[i];
					timer[i] <= {`DLY_W{1'b0}};
				end else if (tick) begin
					timer[i] <= timer[i] + 1'b1;
				end
			end
		end
	end

	// Edge events and pop-up requests, one-cycle pulses
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_event <= {N_IN{1'b0}};
			off_event <= {N_IN{1'b0}};
			popup_req <= {N_IN{1'b0}};
			soft_event <= 4'h0;
			soft_input_d <= 4'h0;
		end else begin
			on_event <= act_edge & on_en;
			off_event <= inact_edge & off_en;
			popup_req <= act_edge & indicate;
			soft_input_d <= soft_input;
			soft_event <= (soft_input ^ soft_input_d) & {4{soft_ev_en}};
		end
	end

	// Source vector: inputs, soft inputs, soft outputs, external signals
	always @* begin
		src = 64'h0000000000000000;
		status32 = 32'h00000000;
		for (i = 0; i < N_IN; i = i + 1) begin
			src[i] = status[i];
			status32[i] = status[i];
		end
		for (i = 0; i < 4; i = i + 1)
			src[N_IN + i] = soft_input[i];
		for (i = 0; i < 6; i = i + 1)
			src[N_IN + 4 + i] = dq[N_RELAY + 6 + i];
		for (i = 0; i < N_EXT; i = i + 1)
			src[N_IN + 10 + i] = ext_source[i];
	end

	// Each destination ORs whichever sources its mask selects
	always @* begin
		for (d = 0; d < ND; d = d + 1)
			drive[d] = |({mask_hi[d], mask_lo[d]} & src);
	end

	// Release level from any of the accepted sources
	assign release_all = rel_wr | release_key | release_comm |
		(rel_en & status32[rel_sel]);

	// Destination state; a live drive outranks the release
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dq <= {ND{1'b0}};
		end else begin
			for (d = 0; d < ND; d = d + 1) begin
				if (d < NL && latch_cfg[d])
					dq[d] <= drive[d] | (dq[d] & ~release_all);
				else
					dq[d] <= drive[d];
			end
		end
	end

	// Destination order: relays, alarm, trip, three general, recorder, soft outs
	assign relay_out = dq[N_RELAY-1:0];
	assign alarm_led = dq[N_RELAY];
	assign trip_led = dq[N_RELAY + 1];
	assign gp_led = dq[N_RELAY + 4:N_RELAY + 2];
	assign waveform_recorder_trigger = dq[N_RELAY + 5];
	assign soft_out = dq[N_RELAY + 11:N_RELAY + 6];

	// Read decode and unmapped detection
	always @* begin
		rdata = 32'h00000000;
		rvalid = 1'b1;
		idx = paddr[6:2];
		didx = paddr[7:3];
		if (paddr == `ADDR_STATUS) begin
			rdata = status32;
		end else if (paddr == `ADDR_SOFT_IN) begin
			rdata[3:0] = soft_input;
		end else if (paddr == `ADDR_CTRL) begin
			rdata[`CTRL_SOFT_EV] = soft_ev_en;
			rdata[`CTRL_REL_SEL_LO + 4:`CTRL_REL_SEL_LO] = rel_sel;
			rdata[`CTRL_REL_EN] = rel_en;
		end else if (paddr == `ADDR_RELEASE) begin
			rdata = 32'h00000000;
		end else if (paddr == `ADDR_DEST) begin
			for (d = 0; d < ND; d = d + 1)
				rdata[d] = dq[d];
		end else if (paddr == `ADDR_LATCH) begin
			for (d = 0; d < NL; d = d + 1)
				rdata[d] = latch_cfg[d];
		end else if (paddr[11:7] == `BASE_CFG && idx < N_IN) begin
			rdata[`DLY_W-1:0] = delay[idx];
			rdata[`CFG_INVERT] = invert[idx];
			rdata[`CFG_INDICATE] = indicate[idx];
			rdata[`CFG_ON_EV] = on_en[idx];
			rdata[`CFG_OFF_EV] = off_en[idx];
		end else if (paddr[11:7] == `BASE_CNT && idx < N_IN) begin
			rdata[`CNT_W-1:0] = count[idx];
		end else if (paddr[11:8] == `BASE_MASK && didx < ND) begin
			rdata = paddr[2] ? mask_hi[didx] : mask_lo[didx];
		end else begin
			rvalid = 1'b0;
		end
	end

	// Read data and error captured in setup, shown in the access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h00000000 : rdata;
			pslverr <= ~rvalid;
		end
	end

	// Register writes and counters; a bus write to a counter beats an edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			invert <= {N_IN{1'b0}};
			indicate <= {N_IN{1'b0}};
			on_en <= {N_IN{1'b0}};
			off_en <= {N_IN{1'b0}};
			for (i = 0; i < N_IN; i = i + 1) begin
				delay[i] <= {`DLY_W{1'b0}};
				count[i] <= {`CNT_W{1'b0}};
			end
			for (d = 0; d < ND; d = d + 1) begin
				mask_lo[d] <= 32'h00000000;
				mask_hi[d] <= 32'h00000000;
			end
			soft_input <= 4'h0;
			soft_ev_en <= 1'b0;
			rel_sel <= 5'h00;
			rel_en <= 1'b0;
			latch_cfg <= {NL{1'b0}};
			rel_wr <= 1'b0;
		end else begin
			rel_wr <= wr && rvalid && paddr == `ADDR_RELEASE;
			for (i = 0; i < N_IN; i = i + 1) begin
				if (act_edge[i])
					count[i] <= count[i] + 1'b1;
			end
			if (wr && rvalid) begin
				if (paddr == `ADDR_SOFT_IN)
					soft_input <= pwdata[3:0];
				if (paddr == `ADDR_CTRL) begin
					soft_ev_en <= pwdata[`CTRL_SOFT_EV];
					rel_sel <= pwdata[`CTRL_REL_SEL_LO + 4:`CTRL_REL_SEL_LO];
					rel_en <= pwdata[`CTRL_REL_EN];
				end
				if (paddr == `ADDR_LATCH)
					latch_cfg <= pwdata[NL-1:0];
				if (paddr[11:7] == `BASE_CFG && idx < N_IN) begin
					// Settings past 60.00 s are clamped to the limit
					if (pwdata[`DLY_W-1:0] > `DLY_MAX)
						delay[idx] <= `DLY_MAX;
					else
						delay[idx] <= pwdata[`DLY_W-1:0];
					invert[idx] <= pwdata[`CFG_INVERT];
					indicate[idx] <= pwdata[`CFG_INDICATE];
					on_en[idx] <= pwdata[`CFG_ON_EV];
					off_en[idx] <= pwdata[`CFG_OFF_EV];
				end
				if (paddr[11:7] == `BASE_CNT && idx < N_IN)
					count[idx] <= pwdata[`CNT_W-1:0];
				if (paddr[11:8] == `BASE_MASK && didx < ND) begin
					if (paddr[2])
						mask_hi[didx] <= pwdata;
					else
						mask_lo[didx] <= pwdata;
				end
			end
		end
	end

endmodule

`default_nettype wire

// *** tb/field_contacts.sv ***
/* Model of the field contacts and protection signals feeding io_matrix.
 Assumes the bench requests levels just after a rising edge. */
`default_nettype none
module field_contacts (
	input wire logic pclk,
	input wire logic [31:0] want,
	input wire logic [15:0] ext_want,
	output var logic [31:0] field_input,
	output var logic [15:0] ext_source
);
timeunit 1ns;
timeprecision 1ns;
// Known levels from time zero
initial begin
	field_input = '0;
	ext_source = '0;
end
// Contacts settle on the edge, since the block wants synchronous inputs
always @(posedge pclk) begin
	field_input <= want;
	ext_source <= ext_want;
end
endmodule
`default_nettype wire

// *** tb/io_matrix_properties.sv ***
/* Port checker for io_matrix.
 Assumes the register map header and a single pclk domain. */
`include "io_matrix_regs.vh"
`default_nettype none
module io_matrix_properties #(
	parameter N_IN = 32,
	parameter N_RELAY = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [N_IN-1:0] on_event,
	input wire logic [N_IN-1:0] off_event,
	input wire logic [N_IN-1:0] popup_req,
	input wire logic [3:0] soft_event,
	input wire logic [3:0] soft_input
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// Steps of a soft input write
sequence s_access;
	psel && penable;
endsequence
sequence s_soft_wr;
	s_access ##0 (pwrite && paddr == `ADDR_SOFT_IN);
endsequence
a_ready_access: assert property (s_access |-> pready)
	else $error("pready missing in access");
a_ready_only: assert property (pready |-> psel && penable)
	else $error("pready outside access");
a_err_nodata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
	else $error("error read with data");
a_soft_write: assert property (s_soft_wr |=> soft_input == $past(pwdata[3:0]))
	else $error("soft input not written");
a_soft_hold: assert property ($changed(soft_input) |-> $past(pwrite && paddr == `ADDR_SOFT_IN))
	else $error("soft input changed alone");
a_soft_cause: assert property (soft_event != 4'h0 |->
	(soft_event & ~($past(soft_input) ^ $past(soft_input, 2))) == 4'h0)
	else $error("soft event without change");
a_event_single: assert property (on_event != '0 |=> (on_event & $past(on_event)) == '0)
	else $error("event pulse too long");
a_edge_exclusive: assert property (off_event != '0 |->
	(off_event & (on_event | popup_req)) == '0)
	else $error("active and inactive edge together");
endmodule
bind io_matrix io_matrix_properties #(.N_IN(N_IN), .N_RELAY(N_RELAY)) props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.on_event(on_event), .off_event(off_event), .popup_req(popup_req),
	.soft_event(soft_event), .soft_input(soft_input)
);
`default_nettype wire

// *** tb/test_io_matrix.sv ***
/* Directed APB bench for io_matrix.
 Assumes TICK_CYCLES of 4, so one delay step is four clocks. */
`include "io_matrix_regs.vh"
`default_nettype none
module test_io_matrix;
timeunit 1ns;
timeprecision 1ns;
localparam logic [11:0] CFG = 12'h100, CNT = 12'h200, MASK = 12'h400;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
logic release_key = 0, release_comm = 0, pready, pslverr, alarm_led, trip_led, rec;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, prdata, rd, want = 0, field_input, on_event, off_event, popup_req;
logic [15:0] ext_want = 0, ext_source;
logic [3:0] soft_event, soft_input;
logic [7:0] relay_out;
logic [2:0] gp_led;
logic [5:0] soft_out;
int fail_count = 0, n_checks = 0, n_on = 0, n_off = 0, n_pop = 0, n_soft = 0;
field_contacts far (.pclk(pclk), .want(want), .ext_want(ext_want),
	.field_input(field_input), .ext_source(ext_source));
io_matrix #(.TICK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .field_input(field_input), .ext_source(ext_source),
	.release_key(release_key), .release_comm(release_comm), .on_event(on_event),
	.off_event(off_event), .popup_req(popup_req), .soft_event(soft_event),
	.soft_input(soft_input), .relay_out(relay_out), .alarm_led(alarm_led),
	.trip_led(trip_led), .gp_led(gp_led), .waveform_recorder_trigger(rec),
	.soft_out(soft_out));
// 100 ns clock
initial forever #50 pclk = ~pclk;
// Pulse tallies, so a pulse seen in any cycle is counted
always @(posedge pclk) begin
	n_on <= n_on + $countones(on_event);
	n_off <= n_off + $countones(off_event);
	n_pop <= n_pop + $countones(popup_req);
	n_soft <= n_soft + $countones(soft_event);
end
task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
	n_checks++;
	if (seen !== exp) begin
		fail_count++;
		$display("BAD %s expected %h seen %h", what, exp, seen);
	end
endtask
task automatic cyc(int n);
	repeat (n) @(posedge pclk);
endtask
// One APB transfer; request held until pready is sampled high
task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
	int n = 0;
	@(posedge pclk);
	psel <= 1;
	pwrite <= wr;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1;
	@(posedge pclk);
	while (pready !== 1'b1 && n < 50) begin
		@(posedge pclk);
		n++;
	end
	// A slave that never answers ends the run through the verdict
	if (n == 50) begin
		fail_count++;
		end_sim();
	end
	rd = prdata;
	err = pslverr;
	psel <= 0;
	penable <= 0;
endtask
task automatic wr(logic [11:0] a, logic [31:0] d);
	apb(1, a, d);
endtask
task automatic rchk(string what, logic [11:0] a, logic [31:0] exp);
	apb(0, a, 32'h0);
	chk(what, rd, exp);
endtask
task automatic end_sim;
	$display("checks %0d mismatches %0d", n_checks, fail_count);
	if (fail_count == 0 && n_checks > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
// Watchdog: the tests need well under 2000 cycles
initial begin
	cyc(20000);
	fail_count++;
	end_sim();
end
initial begin
	cyc(10);
	presetn <= 1;
	rchk("status", `ADDR_STATUS, 0);
	rchk("dest", `ADDR_DEST, 0);
	rchk("unmapped", 12'h0f0, 0);
	chk("slverr", 32'(err), 1);
	wr(`ADDR_CTRL, 32'h1);
	wr(`ADDR_SOFT_IN, 32'h5);
	cyc(3);
	chk("soft_input", 32'(soft_input), 5);
	wr(`ADDR_CTRL, 32'h0);
	wr(`ADDR_SOFT_IN, 32'h0);
	cyc(3);
	chk("soft_event", n_soft, 2);
	$display("test soft inputs done");
	wr(CFG, 32'h000e0000);
	want[0] <= 1;
	cyc(6);
	want[0] <= 0;
	cyc(6);
	chk("on_event", n_on, 1);
	chk("off_event", n_off, 1);
	chk("popup", n_pop, 1);
	rchk("count", CNT, 1);
	wr(CFG + 12'h4, 32'h00010000);
	rchk("inverted", `ADDR_STATUS, 2);
	chk("no event", n_on, 1);
	wr(CFG + 12'h8, 32'h5);
	want[2] <= 1;
	cyc(5);
	want[2] <= 0;
	cyc(30);
	want[2] <= 1;
	cyc(6);
	rchk("short pulse", `ADDR_STATUS, 2);
	cyc(30);
	rchk("delayed", `ADDR_STATUS, 6);
	wr(CNT, 32'hffff);
	want[0] <= 1;
	cyc(4);
	want[0] <= 0;
	rchk("wrap", CNT, 0);
	$display("test field inputs done");
	wr(MASK + 12'h4, 32'h400);
	wr(MASK + 12'h44, 32'h400);
	wr(MASK + 12'h6c, 32'h400);
	wr(MASK + 12'h74, 32'h1);
	wr(MASK + 12'h4c, 32'h400);
	wr(MASK + 12'h5c, 32'h400);
	wr(`ADDR_SOFT_IN, 32'h1);
	ext_want[0] <= 1;
	cyc(3);
	chk("routed", 32'({rec, soft_out, alarm_led, relay_out}), 32'h8301);
	chk("trip gp", 32'({trip_led, gp_led}), 32'ha);
	ext_want[0] <= 0;
	cyc(3);
	chk("follow", 32'({rec, alarm_led, relay_out}), 0);
	chk("trip gp off", 32'({trip_led, gp_led}), 0);
	wr(`ADDR_LATCH, 32'h101);
	for (int k = 0; k < 4; k++) begin
		ext_want[0] <= 1;
		cyc(3);
		ext_want[0] <= 0;
		cyc(3);
		chk("latched", 32'({alarm_led, relay_out}), 32'h101);
		if (k == 3) wr(`ADDR_RELEASE, 32'h1);
		if (k == 2) wr(`ADDR_CTRL, 32'h10300);
		release_key <= (k == 0);
		release_comm <= (k == 1);
		want[3] <= (k == 2);
		cyc(3);
		release_key <= 0;
		release_comm <= 0;
		want[3] <= 0;
		cyc(2);
		chk("released", 32'({alarm_led, relay_out}), 0);
	end
	$display("test matrix done");
	end_sim();
end
endmodule
`default_nettype wire
